// File: ptoc_map.vh
// constants for the periodic timer output and clear control block
`ifndef PTOC_MAP_VH
`define PTOC_MAP_VH

// operating mode field encodings
`define PTOC_MODE_CMP     2'b00
`define PTOC_MODE_CAP     2'b01
`define PTOC_MODE_PWM     2'b10
`define PTOC_MODE_TMR     2'b11

// pin function field encodings
`define PTOC_IO_NONE      2'b00
`define PTOC_IO_LOW       2'b01
`define PTOC_IO_HIGH      2'b10
`define PTOC_IO_TOGGLE    2'b11

// widths and reset values
`define PTOC_CNT_W        10
`define PTOC_CNT_ZERO     10'h000
`define PTOC_CNT_MAX      10'h3FF
`define PTOC_SYNC_RST     2'h0

`endif

// File: ptoc_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps

module ptoc_sync (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // pin in, synchronised out
  input  wire async_in,
  output wire sync_out
);

  reg [1:0] stage_reg;

  // only the second stage is visible to logic
  always @(posedge sys_clk) begin
    if (rst) begin
      stage_reg <= 2'b00;
    end else begin
      stage_reg <= {stage_reg[0], async_in};
    end
  end

  assign sync_out = stage_reg[1];

endmodule // ptoc_sync

// File: ptoc_ctrl.v
// periodic timer output level, polarity, capture source and counter clear control
`timescale 1ns/10ps
`include "ptoc_map.vh"

// Function
// - compare mode: initial level sets pin
// - pwm/pulse: initial level is active level
// - timer/counter mode ignores initial level
// - invert bit flips pin, not in timer or capture
// - capture trigger from io or clock pin
// - clear select one: duty match clears
// - clear select zero: period match/overflow clears
// - overflow clear only when period zero, except capture which always wraps by overflow
// - clear select ignored in pwm/capture
// - mode field decode 00/01/10/11
// - run rising edge restores initial level in compare mode
module ptoc_ctrl (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // control fields
  input  wire [1:0] operating_mode,
  input  wire [1:0] pin_function,
  input  wire       output_initial_level_select,
  input  wire       output_invert,
  input  wire       capture_trigger_source,
  input  wire       counter_clear_select,
  input  wire       counter_run_control,
  input  wire       counter_pause,
  // compare values
  input  wire [9:0] period_compare_value,
  input  wire [9:0] duty_compare_value,
  // pins
  input  wire       timer_io_pin_in,
  input  wire       external_clock_pin,
  output reg        timer_io_pin_out,
  output reg        timer_io_pin_oe,
  // status
  output reg  [9:0] counter_value,
  output reg        duty_match,
  output reg        period_match,
  output reg        capture_trigger,
  output reg        capture_edge
);

  // ------------------------------------------------------------
  // mode decode and input synchronisers
  // ------------------------------------------------------------
  // mode field decode
  wire mode_cmp = (operating_mode == `PTOC_MODE_CMP);
  wire mode_cap = (operating_mode == `PTOC_MODE_CAP);
  wire mode_pwm = (operating_mode == `PTOC_MODE_PWM);
  wire mode_tmr = (operating_mode == `PTOC_MODE_TMR);

  // both pins are asynchronous, so each passes its own two-flop stage
  wire [1:0] pin_raw;
  wire [1:0] pin_sync;
  wire       io_sync;
  wire       ck_sync;

  assign pin_raw = {external_clock_pin, timer_io_pin_in};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin_sync
      ptoc_sync u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (pin_raw[g]),
        .sync_out (pin_sync[g])
      );
    end
  endgenerate

  // bit 0 is the timer pin, bit 1 the external clock pin
  assign io_sync = pin_sync[0];
  assign ck_sync = pin_sync[1];

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  reg [9:0] cnt_reg;
  reg [9:0] cnt_next;
  reg       run_d_reg;
  reg       level_reg;
  reg       level_next;
  reg       trig_d_reg;
  reg       pin_next;

  wire run_rise = counter_run_control & ~run_d_reg;
  wire a_hit    = (cnt_reg == duty_compare_value);
  wire p_hit    = (cnt_reg == period_compare_value);
  wire trig_src = capture_trigger_source ? ck_sync : io_sync;

  // ------------------------------------------------------------
  // counter clear selection
  // ------------------------------------------------------------
  // a zero period means wrap by overflow, never a match clear
  wire period_zero = (period_compare_value == `PTOC_CNT_ZERO);
  // clear select only counts in compare and timer modes
  wire sel_used    = mode_cmp | mode_tmr;
  wire clr_duty    = sel_used & counter_clear_select & a_hit;
  // period comparator clears otherwise; pwm ignores select
  wire clr_period  = ((sel_used & ~counter_clear_select) | mode_pwm) & ~period_zero & p_hit;

  // counter with run edge restart; pause holds the count
  always @* begin
    cnt_next = cnt_reg;
    if (run_rise) begin
      cnt_next = `PTOC_CNT_ZERO;
    end else if (counter_run_control && !counter_pause) begin
      if (clr_duty || clr_period) begin
        cnt_next = `PTOC_CNT_ZERO;
      end else begin
        // wraps at all ones by itself, which is the overflow clear
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  // internal output level before inversion
  always @* begin
    level_next = level_reg;
    if (mode_cmp) begin
      if (run_rise) begin
        level_next = output_initial_level_select;
      end else if (counter_run_control && a_hit) begin
        case (pin_function)
          `PTOC_IO_LOW:    level_next = 1'b0;
          `PTOC_IO_HIGH:   level_next = 1'b1;
          `PTOC_IO_TOGGLE: level_next = ~level_reg;
          default:         level_next = level_reg;
        endcase
      end
    end else if (mode_pwm) begin
      // active phase while below duty, active level from select
      case (pin_function)
        `PTOC_IO_NONE:  level_next = ~output_initial_level_select;
        `PTOC_IO_LOW:   level_next = output_initial_level_select;
        default: begin
          if (counter_run_control && cnt_next < duty_compare_value) begin
            level_next = output_initial_level_select;
          end else begin
            level_next = ~output_initial_level_select;
          end
        end
      endcase
    end
    // timer and capture modes leave level alone
  end

  // final drive is level xor invert
  always @* begin
    pin_next = level_next ^ output_invert;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // counter and run edge; run history resets low, so run high at release restarts
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg       <= `PTOC_CNT_ZERO;
      run_d_reg     <= 1'b0;
      counter_value <= `PTOC_CNT_ZERO;
    end else begin
      cnt_reg       <= cnt_next;
      run_d_reg     <= counter_run_control;
      // separate copy so the port comes straight from a flop
      counter_value <= cnt_next;
    end
  end

  // level and pin drive move on the same edge, so the pin never lags the level
  always @(posedge sys_clk) begin
    if (rst) begin
      level_reg        <= 1'b0;
      timer_io_pin_out <= 1'b0;
      timer_io_pin_oe  <= 1'b0;
    end else begin
      level_reg        <= level_next;
      // pin unused in timer and capture modes
      timer_io_pin_oe  <= mode_cmp | mode_pwm;
      timer_io_pin_out <= (mode_cmp | mode_pwm) ? pin_next : 1'b0;
    end
  end

  // comparator match pulses
  always @(posedge sys_clk) begin
    if (rst) begin
      duty_match   <= 1'b0;
      period_match <= 1'b0;
    end else begin
      duty_match   <= counter_run_control & a_hit;
      // no period pulse while the duty comparator owns the clear
      period_match <= counter_run_control & p_hit & ~(sel_used & counter_clear_select);
    end
  end

  // capture level and edge; edge polarity filtering is left to the outside
  // limitation: a source idling high gives one stray edge after reset
  always @(posedge sys_clk) begin
    if (rst) begin
      trig_d_reg      <= 1'b0;
      capture_trigger <= 1'b0;
      capture_edge    <= 1'b0;
    end else begin
      trig_d_reg      <= trig_src;
      capture_trigger <= mode_cap & trig_src;
      // edge flag on selected source, either direction
      capture_edge    <= mode_cap & (trig_src ^ trig_d_reg);
    end
  end

endmodule // ptoc_ctrl

// File: ptoc_ctrl_asserts.sv
// assertion checker for the timer output and clear control
`timescale 1ns/10ps
module ptoc_asserts (
  // clock and reset
  input wire       sys_clk,
  input wire       rst,
  // controls
  input wire [1:0] operating_mode,
  input wire [1:0] pin_function,
  input wire       output_initial_level_select,
  input wire       output_invert,
  input wire       counter_clear_select,
  input wire       counter_run_control,
  input wire       counter_pause,
  input wire [9:0] period_compare_value,
  input wire [9:0] duty_compare_value,
  // watched outputs
  input wire       timer_io_pin_out,
  input wire       timer_io_pin_oe,
  input wire [9:0] counter_value
);
  // ----
  // shorthands
  // ----
  wire [1:0] md   = operating_mode;
  wire [9:0] cv   = counter_value;
  wire       il   = output_initial_level_select;
  wire       iv   = output_invert;
  wire       cs   = counter_clear_select;
  wire       o    = timer_io_pin_out;
  wire       run  = counter_run_control;
  wire       go   = run && !counter_pause;
  wire       ct   = md[1] == md[0];
  wire       pw   = md == 2'h2;
  wire       at_d = cv == duty_compare_value;
  wire       at_p = cv == period_compare_value;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tmr_idle: assert property (md == 2'h3 |=> !timer_io_pin_oe && !o)
    else $error("timer mode drives pin");
  // first edge after reset already loads oe from the mode; the check skips that edge
  a_oe_drive: assert property (!md[0] && !$past(rst) |=> timer_io_pin_oe)
    else $error("pin not driven");
  a_run_init: assert property (md == 2'h0 && $rose(run) |=> o == ($past(il) ^ $past(iv)) && cv == 10'h000)
    else $error("run start level wrong");
  a_duty_clr: assert property (go && ct && cs && at_d |=> cv == 10'h000)
    else $error("duty match did not clear");
  a_period_clr: assert property (go && ct && !cs && at_p && period_compare_value != 10'h000 |=> cv == 10'h000)
    else $error("period match did not clear");
  a_no_early: assert property (go && ct && !cs && !at_p && cv != 10'h3FF && !$rose(run) |=> cv == $past(cv) + 10'h001)
    else $error("counter cleared early");
  // pin function 11 is left out, though it counts through duty match like 10
  a_pwm_hold: assert property (go && pw && pin_function != 2'h3 && cs && at_d && !at_p && cv != 10'h3FF && !$rose(run)
    |=> cv == $past(cv) + 10'h001)
    else $error("clear select used in pwm");
  a_pwm_level: assert property (pw && !pin_function[1] |=> o == ($past(il) ^ $past(iv) ^ !$past(pin_function[0])))
    else $error("pwm forced level wrong");
  c_duty: cover property (go && ct && cs && at_d);
  c_start: cover property (md == 2'h0 && $rose(run));
  c_wrap: cover property (go && cv == 10'h3FF);
endmodule // ptoc_asserts

// File: ptoc_ctrl_tb.sv
// self-checking bench for the timer output and clear control
`timescale 1ns/10ps
module ptoc_ctrl_tb;
  logic       sys_clk = 0, rst = 1, counter_pause = 0, timer_io_pin_in = 0, external_clock_pin = 0;
  logic [1:0] operating_mode = 0, pin_function = 0;
  logic       output_initial_level_select = 0, output_invert = 0, capture_trigger_source = 0;
  logic       counter_clear_select = 0, counter_run_control = 0, timer_io_pin_out, timer_io_pin_oe;
  logic [9:0] period_compare_value = 0, duty_compare_value = 0, counter_value;
  logic       duty_match, period_match, capture_trigger, capture_edge;
  int         err_total = 0, n_compared = 0, e;
  ptoc_ctrl i_dut (.*);
  initial forever #2 sys_clk = ~sys_clk;
  // ----
  // tasks
  // ----
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [9:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // run low for one edge so the next edge sees a rising run bit
  task start(input logic [1:0] m, input logic c, input logic [9:0] p, d);
    counter_run_control = 0;
    operating_mode = m;
    counter_clear_select = c;
    period_compare_value = p;
    duty_compare_value = d;
    step(1);
    counter_run_control = 1;
    step(1);
  endtask
  // expected count restarts after lim
  task count(input logic [1:0] m, input logic c, input logic [9:0] p, d, lim, input int n);
    logic [9:0] x;
    start(m, c, p, d);
    x = 10'h000;
    repeat (n) begin
      chk(counter_value, x);
      x = (x == lim) ? 10'h000 : x + 10'h001;
      step(1);
    end
  endtask
  // match pulses and compare-mode pin, counter restarting after p
  task flags(input logic [9:0] p, d, input int n);
    logic [9:0] x;
    logic       lv;
    x = 10'h000;
    lv = output_initial_level_select;
    repeat (n) begin
      step(1);
      chk(duty_match, x == d);
      chk(period_match, x == p);
      if (x == d) lv = ~lv;
      chk(timer_io_pin_out, lv ^ output_invert);
      x = (x == p) ? 10'h000 : x + 10'h001;
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    step(5);
    rst = 0;
    // level, invert and forced pwm state over all combinations
    for (e = 0; e < 8; e++) begin
      output_initial_level_select = e[0];
      output_invert = e[1];
      pin_function = {1'b0, e[2]};
      start(2'h0, 0, 10'h000, 10'h005);
      chk(timer_io_pin_out, e[0] ^ e[1]);
      operating_mode = 2'h2;
      step(1);
      chk(timer_io_pin_out, e[0] ^ e[1] ^ !e[2]);
      operating_mode = 2'h3;
      step(1);
      chk({timer_io_pin_oe, timer_io_pin_out}, 10'h000);
    end
    count(2'h0, 0, 10'h005, 10'h003, 10'h005, 14);
    count(2'h3, 1, 10'h002, 10'h004, 10'h004, 12);
    output_initial_level_select = 1;
    output_invert = 1;
    pin_function = 2'h3;
    start(2'h0, 0, 10'h005, 10'h003);
    flags(10'h005, 10'h003, 14);
    pin_function = 2'h2;
    output_invert = 0;
    start(2'h2, 1, 10'h006, 10'h002);
    for (e = 0; e < 14; e++) begin
      chk(timer_io_pin_out, (e % 7) < 2);
      step(1);
    end
    count(2'h2, 1, 10'h006, 10'h002, 10'h006, 16);
    count(2'h0, 0, 10'h000, 10'h005, 10'h3FF, 1030);
    // pins pass two flops plus the output register
    operating_mode = 2'h1;
    for (e = 0; e < 4; e++) begin
      capture_trigger_source = e[0];
      timer_io_pin_in = e[1];
      external_clock_pin = !e[1];
      step(4);
      chk(capture_trigger, e[0] ^ e[1]);
    end
    capture_trigger_source = 0;
    step(4);
    timer_io_pin_in = 0;
    step(3);
    chk(capture_edge, 1);
    step(1);
    chk(capture_edge, 0);
    // second reset in mid-run, run low so no restart follows release
    counter_run_control = 0;
    rst = 1;
    step(2);
    chk({timer_io_pin_oe, timer_io_pin_out, capture_trigger}, 10'h000);
    chk(counter_value, 10'h000);
    rst = 0;
    step(2);
    print_verdict;
  end
endmodule // ptoc_ctrl_tb
bind ptoc_ctrl ptoc_asserts i_chk (.*);
